// [hw/sadc_pkg.sv]
package sadc_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int unsigned RESULT_BITS   = 16;
  localparam int unsigned CONFIG_BITS   = 2;
  localparam int unsigned SAMPLE_SCK_1CH = 16;
  localparam int unsigned SAMPLE_SCK_2CH = 14;
  localparam int unsigned XFER_SCK      = 16;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned CONVERT_STROBE_MAX_NS   = 3200;
  localparam int unsigned CONVERT_STROBE_MAX_H_NS = 3300;
  localparam int unsigned CONVERT_STROBE_TYP_NS   = 2750;
  localparam int unsigned CONVERT_STROBE_CYC      = (CONVERT_STROBE_MAX_NS * CLK_MHZ) / 1000;
  localparam int unsigned CONVERT_STROBE_TYP_CYC  = (CONVERT_STROBE_TYP_NS * CLK_MHZ) / 1000;
  localparam int unsigned SCK_HALF_CYC  = 8;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [1:0]  CONFIG_RST    = 2'h2;
  localparam logic [15:0] RESULT_RST    = 16'h0000;

endpackage

// [hw/sadc_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface sadc_link_if;
  logic convert_strobe;
  logic sck;
  logic serial_config_in;
  logic serial_result_out;
  logic serial_result_oe;
  // Host reads a pulled-down line while the device floats
  logic serial_result_line;
  assign serial_result_line = serial_result_oe ? serial_result_out : 1'b0;

  modport dev
  (
    input  convert_strobe, sck, serial_config_in,
    output serial_result_out, serial_result_oe
  );
  modport host
  (
    output convert_strobe, sck, serial_config_in,
    input  serial_result_line
  );
endinterface
`default_nettype wire

// [hw/sadc_device.sv]
// Notes on behaviour
// - Convert strobe rising starts a conversion
// - Strobe high after conversion means sleep
// - Strobe low enables output, shifts result
// - Conversion finishes within its maximum time
// - Host holds strobe high for conversion
// - Host holds strobe low sixteen clocks
// - Host gives enough sampling clocks
// - New output bit after falling clock
// - Output floats once the strobe rises
// - Strobe low around all rising edges
// - Config input sampled on rising edges
// - Config word shifted in during transfer
// - Bits pick mode then channel/polarity
// - Extra config bits ignored until next cycle
// - Zeros after the result is shifted
// - Host captures data on rising edge
`timescale 1ns/1ps
`default_nettype none
module sadc_device
#(
  parameter int unsigned CONVERT_STROBE_CYCLES = sadc_pkg::CONVERT_STROBE_TYP_CYC,
  parameter bit          TWO_CHANNEL = 1'b1
)
(
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_arst_n,
  // Link
  sadc_link_if.dev         link,
  // Converter core side
  input  wire logic [15:0] i_sample_code,
  output logic      [1:0]  o_mux_config,
  output logic             o_sampling,
  output logic             o_converting,
  output logic             o_sleep
);

  typedef enum logic [1:0] {SADC_ST_IDLE, SADC_ST_CONVERT_STROBE, SADC_ST_SLEEP, SADC_ST_XFER}
    sadc_state_t;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [1:0] convert_strobe_sync_r;
  logic [1:0] sck_sync_r;
  logic [1:0] cfg_sync_r;
  logic       convert_strobe_d_r;
  logic       sck_d_r;

  // Two flops per pin, then a delayed copy for edge finding
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      // Strobe idles high, so reset to that level to avoid a false rise
      convert_strobe_sync_r <= 2'h3;
      sck_sync_r  <= 2'h0;
      cfg_sync_r  <= 2'h0;
      convert_strobe_d_r    <= 1'b1;
      sck_d_r     <= 1'b0;
    end
    else
    begin
      convert_strobe_sync_r <= {convert_strobe_sync_r[0], link.convert_strobe};
      sck_sync_r  <= {sck_sync_r[0], link.sck};
      cfg_sync_r  <= {cfg_sync_r[0], link.serial_config_in};
      convert_strobe_d_r    <= convert_strobe_sync_r[1];
      sck_d_r     <= sck_sync_r[1];
    end
  end

  // Edge decode
  wire convert_strobe_s    = convert_strobe_sync_r[1];
  wire convert_strobe_rise = convert_strobe_s & ~convert_strobe_d_r;
  wire convert_strobe_fall = ~convert_strobe_s & convert_strobe_d_r;
  wire sck_rise  = sck_sync_r[1] & ~sck_d_r;
  wire sck_fall  = ~sck_sync_r[1] & sck_d_r;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  sadc_state_t  state_r;
  sadc_state_t  state_nxt;
  logic [15:0]  convert_strobe_cnt_r;
  logic [15:0]  shift_r;
  logic [1:0]   cfg_shift_r;
  logic [1:0]   cfg_cnt_r;
  logic [1:0]   mux_cfg_r;
  logic         res_bit_r;
  logic         oe_r;

  wire convert_strobe_done = (convert_strobe_cnt_r == 16'(CONVERT_STROBE_CYCLES - 1));

  // Next state
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      SADC_ST_IDLE:  if (convert_strobe_rise) state_nxt = SADC_ST_CONVERT_STROBE;
      SADC_ST_CONVERT_STROBE:  if (convert_strobe_done) state_nxt = convert_strobe_s ? SADC_ST_SLEEP : SADC_ST_XFER;
      SADC_ST_SLEEP: if (convert_strobe_fall) state_nxt = SADC_ST_XFER;
      SADC_ST_XFER:  if (convert_strobe_rise) state_nxt = SADC_ST_CONVERT_STROBE;
    endcase
  end

  // State, conversion timer and output path
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_r    <= SADC_ST_IDLE;
      convert_strobe_cnt_r <= 16'h0000;
      shift_r    <= sadc_pkg::RESULT_RST;
      res_bit_r  <= 1'b0;
      oe_r       <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      convert_strobe_cnt_r <= (state_r == SADC_ST_CONVERT_STROBE) ? convert_strobe_cnt_r + 16'h0001 : 16'h0000;
      if (convert_strobe_rise)
      begin
        oe_r <= 1'b0;
      end
      else if (!convert_strobe_s && (state_r == SADC_ST_IDLE || state_r == SADC_ST_SLEEP ||
               state_r == SADC_ST_XFER || (state_r == SADC_ST_CONVERT_STROBE && convert_strobe_done)))
      begin
        oe_r <= 1'b1;
      end
      if (state_r == SADC_ST_CONVERT_STROBE && convert_strobe_done)
      begin
        // Latch result; MSB drives first, zeros refill the tail
        res_bit_r <= i_sample_code[15];
        shift_r <= {i_sample_code[14:0], 1'b0};
      end
      else if (state_r == SADC_ST_XFER && !convert_strobe_s && sck_fall)
      begin
        res_bit_r <= shift_r[15];
        shift_r <= {shift_r[14:0], 1'b0};
      end
    end
  end

  // Configuration word capture
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cfg_shift_r <= 2'h0;
      cfg_cnt_r   <= 2'h0;
      mux_cfg_r   <= sadc_pkg::CONFIG_RST;
    end
    else if (convert_strobe_rise)
    begin
      cfg_cnt_r <= 2'h0;
      if (cfg_cnt_r == 2'(sadc_pkg::CONFIG_BITS))
      begin
        mux_cfg_r <= cfg_shift_r;
      end
    end
    else if (TWO_CHANNEL && state_r == SADC_ST_XFER && !convert_strobe_s && sck_rise &&
             cfg_cnt_r != 2'(sadc_pkg::CONFIG_BITS))
    begin
      cfg_shift_r <= {cfg_shift_r[0], cfg_sync_r[1]};
      cfg_cnt_r   <= cfg_cnt_r + 2'h1;
    end
  end

  // Outputs
  assign link.serial_result_out = res_bit_r;
  assign link.serial_result_oe  = oe_r;
  assign o_mux_config = mux_cfg_r;  // bit1 single-ended, bit0 channel/polarity
  assign o_sampling   = (state_r == SADC_ST_XFER);
  assign o_converting = (state_r == SADC_ST_CONVERT_STROBE);
  assign o_sleep      = (state_r == SADC_ST_SLEEP);

endmodule
`default_nettype wire

// [hw/sadc_host.sv]
`timescale 1ns/1ps
`default_nettype none
module sadc_host
#(
  parameter int unsigned CONVERT_STROBE_CYCLES = sadc_pkg::CONVERT_STROBE_CYC,
  parameter int unsigned HALF_CYC    = sadc_pkg::SCK_HALF_CYC
)
(
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_arst_n,
  // User request
  input  wire logic        i_start,
  input  wire logic [1:0]  i_mux_config,
  output logic             o_busy,
  output logic             o_valid,
  output logic      [15:0] o_result,
  // Link
  sadc_link_if.host        link
);

  typedef enum logic [1:0] {SADCH_IDLE, SADCH_CONVERT_STROBE, SADCH_XFER, SADCH_HOLD} sadc_hstate_t;

  sadc_hstate_t state_r;
  logic [15:0]  cnt_r;
  logic [7:0]   div_r;
  logic [4:0]   bit_r;
  logic         convert_strobe_r;
  logic         sck_r;
  logic         cfg_bit_r;
  logic [1:0]   cfg_r;
  logic [1:0]   res_sync_r;
  logic [15:0]  rx_r;
  logic         valid_r;

  wire half_tick = (div_r == 8'(HALF_CYC - 1));

  // Strobe high for conversion, then 16 clocks low with capture on rise
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_r <= SADCH_IDLE; cnt_r <= 16'h0000; div_r <= 8'h00; bit_r <= 5'h00;
      convert_strobe_r <= 1'b1; sck_r <= 1'b0; cfg_bit_r <= 1'b0; cfg_r <= 2'h0;
      res_sync_r <= 2'h0; rx_r <= 16'h0000; valid_r <= 1'b0;
    end
    else
    begin
      res_sync_r <= {res_sync_r[0], link.serial_result_line};
      valid_r <= 1'b0;
      unique case (state_r)
        SADCH_IDLE:
          if (i_start)
          begin
            convert_strobe_r <= 1'b1; cfg_r <= i_mux_config; cnt_r <= 16'h0000;
            state_r <= SADCH_CONVERT_STROBE;
          end
        SADCH_CONVERT_STROBE:
          if (cnt_r == 16'(CONVERT_STROBE_CYCLES + 4))
          begin
            convert_strobe_r <= 1'b0; cfg_bit_r <= cfg_r[1]; div_r <= 8'h00; bit_r <= 5'h00;
            state_r <= SADCH_XFER;
          end
          else cnt_r <= cnt_r + 16'h0001;
        SADCH_XFER:
          if (half_tick)
          begin
            div_r <= 8'h00;
            sck_r <= ~sck_r;
            if (!sck_r)
            begin
              rx_r <= {rx_r[14:0], res_sync_r[1]};
            end
            else
            begin
              cfg_bit_r <= cfg_r[0];
              bit_r <= bit_r + 5'h01;
              if (bit_r == 5'(sadc_pkg::XFER_SCK - 1)) state_r <= SADCH_HOLD;
            end
          end
          else div_r <= div_r + 8'h01;
        SADCH_HOLD:
          if (half_tick)
          begin
            convert_strobe_r <= 1'b1; valid_r <= 1'b1; state_r <= SADCH_IDLE;
          end
          else div_r <= div_r + 8'h01;
      endcase
    end
  end

  assign link.convert_strobe   = convert_strobe_r;
  assign link.sck              = sck_r;
  assign link.serial_config_in = cfg_bit_r;
  assign o_busy   = (state_r != SADCH_IDLE);
  assign o_valid  = valid_r;
  assign o_result = rx_r;

endmodule
`default_nettype wire

// [verif/sadc_link_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module sadc_link_monitor
#(
  parameter int unsigned CONVERT_STROBE_CYCLES = 20,
  parameter int unsigned HALF_CYC    = 8
)
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Link
  input wire logic convert_strobe,
  input wire logic sck,
  input wire logic serial_config_in,
  input wire logic serial_result_out,
  input wire logic serial_result_oe
);
  // ****
  // Strobe run length
  // ****
  logic        prev_r;
  logic [15:0] run_r;

  // Cycles since the strobe last changed level
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      prev_r <= 1'b1;
      run_r  <= 16'h0000;
    end
    else
    begin
      prev_r <= convert_strobe;
      run_r  <= (convert_strobe != prev_r) ? 16'h0001 : run_r + 16'h0001;
    end
  end

  // ****
  // Link checks
  // ****
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  // Bit launched on a falling edge stands past the next rising edge
  sequence s_rise_hold;
    ##1 $stable(serial_result_out) [*6];
  endsequence

  sequence s_cfg_hold;
    $stable(serial_config_in) ##1 $stable(serial_config_in);
  endsequence

  hiz_on_rise_a: assert property ($rose(convert_strobe) |-> ##[1:6] !serial_result_oe)
    else $error("result output not released after strobe rise");
  oe_off_high_a: assert property (convert_strobe [*7] |-> !serial_result_oe)
    else $error("result output driven while strobe high");
  oe_on_fall_a: assert property ($fell(convert_strobe) |-> ##[1:6] serial_result_oe)
    else $error("result output not enabled after strobe fall");
  bit_hold_a: assert property ($rose(sck) && serial_result_oe |-> s_rise_hold)
    else $error("result bit moved after rising clock");
  change_low_a: assert property ($changed(serial_result_out) && serial_result_oe
    && $past(serial_result_oe) |-> !sck)
    else $error("result bit moved while clock high");
  clk_in_low_a: assert property ($rose(sck) |-> !convert_strobe)
    else $error("rising clock outside low strobe");
  cfg_stable_a: assert property ($rose(sck) |-> s_cfg_hold)
    else $error("config input moved at rising clock");
  high_time_a: assert property ($fell(convert_strobe) |-> run_r >= CONVERT_STROBE_CYCLES)
    else $error("strobe high shorter than conversion");
  low_time_a: assert property ($rose(convert_strobe) |-> run_r >= 32 * HALF_CYC)
    else $error("strobe low shorter than sixteen clocks");
endmodule
`default_nettype wire

// [verif/tb_serial_adc_convert_interface.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got); \
    end \
  end
module tb_serial_adc_convert_interface;
  logic        i_mclk;
  logic        i_arst_n;
  logic        i_start;
  logic [1:0]  i_mux_config;
  logic [15:0] i_sample_code;
  logic        o_busy;
  logic        o_valid;
  logic [15:0] o_result;
  logic [1:0]  mux_cfg;
  logic        converting;
  logic        sleep;
  logic        sampling;
  logic [15:0] res;
  logic [15:0] codes [4] = '{16'hFFFF, 16'h0000, 16'h8001, 16'h5AA5};
  int          failures = 0;
  int          n_compared = 0;

  // ****
  // Both ends across one link
  // ****
  sadc_link_if link ();
  sadc_device #(.CONVERT_STROBE_CYCLES(20)) i_sadc_device
  (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .link(link), .i_sample_code(i_sample_code),
    .o_mux_config(mux_cfg), .o_sampling(sampling), .o_converting(converting),
    .o_sleep(sleep)
  );
  sadc_host #(.CONVERT_STROBE_CYCLES(24), .HALF_CYC(8)) i_sadc_host
  (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_start(i_start), .i_mux_config(i_mux_config),
    .o_busy(o_busy), .o_valid(o_valid), .o_result(o_result), .link(link)
  );
  sadc_link_monitor #(.CONVERT_STROBE_CYCLES(20), .HALF_CYC(8)) i_sadc_link_monitor
  (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .convert_strobe(link.convert_strobe),
    .sck(link.sck), .serial_config_in(link.serial_config_in),
    .serial_result_out(link.serial_result_out), .serial_result_oe(link.serial_result_oe)
  );

  // Clock
  initial i_mclk = 1'b0;
  always #5 i_mclk = ~i_mclk;

  // Verdict and end of run
  task tally_and_finish;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One request through the host, result taken with the valid pulse
  task xfer(input logic [1:0] cfg, output logic [15:0] r);
    int n;
    @(posedge i_mclk);
    i_mux_config <= cfg;
    i_start      <= 1'b1;
    @(posedge i_mclk);
    i_start <= 1'b0;
    n = 0;
    while (o_valid !== 1'b1 && n < 2000)
    begin
      @(posedge i_mclk);
      n++;
    end
    r = o_result;
    if (n == 2000)
    begin
      failures++;
      tally_and_finish();
    end
  endtask

  // Main sequence
  initial
  begin
    i_arst_n      = 1'b0;
    i_start       = 1'b0;
    i_mux_config  = 2'h0;
    i_sample_code = 16'h0000;
    repeat (3) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    @(posedge i_mclk);
    `CHK("mux reset", sadc_pkg::CONFIG_RST, mux_cfg);
    `CHK("oe reset", 1'b0, link.serial_result_oe);
    for (int i = 0; i < 4; i++)
    begin
      i_sample_code <= codes[i];
      xfer(2'(i), res);
      xfer(2'(i), res);
      `CHK("result", codes[i], res);
      `CHK("host busy", 1'b0, o_busy);
      repeat (8) @(posedge i_mclk);
      `CHK("mux config", 2'(i), mux_cfg);
      `CHK("converting", 1'b1, converting);
      repeat (40) @(posedge i_mclk);
      `CHK("sleep", 1'b1, sleep);
      `CHK("sampling", 1'b0, sampling);
      `CHK("output float", 1'b0, link.serial_result_oe);
    end
    tally_and_finish();
  end

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge i_mclk);
    failures++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
